// [rtl/pcf_pkg.sv]
// Purpose: shared constants and types for the pack configuration and flag block
// Assumes: 32-bit APB data, one aligned word per register
// Notes:   threshold words hold two 16-bit fields, low field in bits 15:0
package pcf_pkg;

  localparam int unsigned PCF_AW = 8;

  // register byte addresses
  localparam logic [PCF_AW-1:0] ADDR_CONFIG   = 8'h00;
  localparam logic [PCF_AW-1:0] ADDR_FLAGS    = 8'h04;
  localparam logic [PCF_AW-1:0] ADDR_THR_BASE = 8'h08;
  localparam logic [PCF_AW-1:0] ADDR_THR_LAST = 8'h2C;
  localparam logic [PCF_AW-1:0] ADDR_CFG_LOC  = 8'h30;

  // threshold word indices, counted from ADDR_THR_BASE
  localparam int unsigned THR_WORDS   = 10;
  localparam int unsigned W_OTC_LVL   = 0; // {recovery, threshold}
  localparam int unsigned W_OTC_TIME  = 1; // {time, charge current threshold}
  localparam int unsigned W_OTD_LVL   = 2; // {recovery, threshold}
  localparam int unsigned W_OTD_TIME  = 3; // {time, discharge current threshold}
  localparam int unsigned W_TAPER     = 4; // {taper voltage, taper current}
  localparam int unsigned W_CHGV      = 5; // {taper window, charging voltage}
  localparam int unsigned W_INHIBIT   = 6; // {high, low}
  localparam int unsigned W_SUSPEND   = 7; // {high, low}
  localparam int unsigned W_ALARMS    = 8; // {full charge threshold, terminate threshold}
  localparam int unsigned W_HYST      = 9; // {zero, temperature hysteresis}

  localparam logic [31:0] THR_RESET    = 32'h0000_0000;
  localparam logic [31:0] ALARMS_RESET = 32'hFFFF_FFFF;

  // storage location of the configuration word
  localparam logic [7:0] CFG_SUBCLASS        = 8'h40;
  localparam logic [7:0] CFG_SUBCLASS_OFFSET = 8'h00;

  // configuration word fields
  localparam int unsigned BIT_RESCOMP  = 15;
  localparam int unsigned BIT_ADC_GROUND_SELECT   = 11;
  localparam int unsigned BIT_WAKERNG  = 10;
  localparam int unsigned BIT_RSEL_HI  = 9;
  localparam int unsigned BIT_RSEL_LO  = 8;
  localparam int unsigned BIT_RESSTEP  = 6;
  localparam int unsigned BIT_SLEEPOK  = 5;
  localparam int unsigned BIT_RMFULL   = 4;
  localparam int unsigned BIT_SDPP     = 3;
  localparam int unsigned BIT_SDPOL    = 2;
  localparam int unsigned BIT_SDEN     = 1;
  localparam int unsigned BIT_EXTTHERM = 0;
  localparam logic [15:0] CFG_RESET    = 16'h0177;
  localparam logic [15:0] CFG_MASK     = 16'h8F7F;

  // flag register fields
  localparam int unsigned FLG_OTC  = 0;
  localparam int unsigned FLG_OTD  = 1;
  localparam int unsigned FLG_INH  = 2;
  localparam int unsigned FLG_SUSP = 3;
  localparam int unsigned FLG_CHG  = 4;
  localparam int unsigned FLG_TERM = 5;
  localparam int unsigned FLG_FULL = 6;

  // charge termination
  localparam logic [1:0]  TAPER_WINDOWS  = 2'd2;
  localparam logic [23:0] TAPER_MIN_CMAH = 24'd25; // 0.25 mAh in 0.01 mAh units
  localparam logic [15:0] ALARM_OFF      = 16'hFFFF;

  // one measurement set, valid with the update strobe
  typedef struct packed {
    logic signed [15:0] temperature;  // 0.1 K
    logic signed [15:0] avg_current;  // mA, positive is charge
    logic        [15:0] voltage;      // mV
    logic signed [15:0] cap_delta;    // 0.01 mAh since last update
    logic        [15:0] soc;          // percent
    logic        [15:0] full_capacity;
    logic        [15:0] remaining_in;
  } pcf_meas_t;

endpackage

// [rtl/pcf_flags.sv]
// Purpose: pack configuration word and temperature/charge flag logic behind APB
// Assumes: measurement set and update strobe come from logic on pclk
// Notes:   zero-wait APB slave; unmapped addresses answer with pslverr
// Summary of operation
// - keep the 16-bit configuration word, stored at subclass 64 offset 0
// - high bit7 enables no-load rate compensation of reserve capacity, default 0
// - high bit3 picks the adc ground reference pin, default 0
// - high bits 2..0 configure the current wake function, defaults 0/0/1
// - low bit6 enables resistance factor stepping before updates stop, default 1
// - low bit5 allows sleep entry when conditions permit, default 1
// - low bit4 loads remaining capacity with full capacity on termination
// - low bit3 makes the shutdown pin push-pull, default 0
// - low bit2 sets shutdown pin level when ready for shutdown, default 1
// - low bit1 enables the shutdown feature, default 1
// - low bit0 selects external thermistor, clear picks on-chip sensor, default 1
// - set charge over-temperature flag after configured time; zero time disables
// - clear charge over-temperature flag at the recovery temperature
// - set discharge over-temperature flag after configured time; zero time disables
// - clear discharge over-temperature flag at the recovery temperature
// - terminate charge after two taper windows meeting current, capacity, voltage
// - terminate alarm threshold of -1 sets terminate indication on taper only
// - full charge threshold of -1 sets full indication on taper only
// - charge inhibit outside inhibit limits, clears inside hysteresis-narrowed range
// - charge suspend outside suspend limits, clears inside narrowed inhibit range
`timescale 1ns/1ns
`default_nettype none
module pcf_flags
  import pcf_pkg::*;
(
  // apb
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [PCF_AW-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // measurements
  input  wire logic              meas_update,
  input  wire pcf_meas_t         meas,
  input  wire logic              ready_for_shutdown,
  // configuration outputs
  output logic                   reserve_rate_comp_en,
  output logic                   adc_ground_select,
  output logic                   wake_range_select,
  output logic                   sense_res_sel_hi,
  output logic                   sense_res_sel_lo,
  output logic                   res_factor_step_en,
  output logic                   sleep_allowed,
  output logic                   external_thermistor_sel,
  output logic                   shutdown_feature_en,
  // shutdown pin
  output logic                   shutdown_pin_o,
  output logic                   shutdown_pin_oe,
  // status
  output logic                   overtemp_charge_flag,
  output logic                   overtemp_discharge_flag,
  output logic                   charge_inhibit_flag,
  output logic                   charge_suspend_flag,
  output logic                   charge_active_flag,
  output logic                   terminate_charge_flag,
  output logic                   full_charge_flag,
  output logic                   charge_term_pulse,
  output logic      [15:0]       remaining_capacity_value
);

  logic [15:0] cfg_q;
  logic [31:0] thr_q [THR_WORDS];
  logic        wr_en;
  logic        rd_hit;
  logic        in_thr;
  logic [3:0]  thr_idx;

  assign in_thr  = (paddr >= ADDR_THR_BASE) && (paddr <= ADDR_THR_LAST) && (paddr[1:0] == 2'b00);
  assign thr_idx = 4'((paddr - ADDR_THR_BASE) >> 2);
  assign rd_hit  = (paddr == ADDR_CONFIG) || (paddr == ADDR_FLAGS) || in_thr ||
                   (paddr == ADDR_CFG_LOC);
  assign wr_en   = psel && penable && pwrite;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !rd_hit;

  // configuration word, unused bits stay zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q <= CFG_RESET;
    end else if (wr_en && paddr == ADDR_CONFIG) begin
      if (pstrb[0]) cfg_q[7:0]  <= pwdata[7:0] & CFG_MASK[7:0];
      if (pstrb[1]) cfg_q[15:8] <= pwdata[15:8] & CFG_MASK[15:8];
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < THR_WORDS; gi++) begin : g_thr
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          thr_q[gi] <= (gi == W_ALARMS) ? ALARMS_RESET : THR_RESET;
        end else if (wr_en && in_thr && thr_idx == 4'(gi)) begin
          for (int b = 0; b < 4; b++) begin
            if (pstrb[b]) thr_q[gi][8*b +: 8] <= pwdata[8*b +: 8];
          end
        end
      end
    end
  endgenerate

  // field views of the threshold words
  logic signed [15:0] otc_thr, otc_rec, chg_cur_thr, otd_thr, otd_rec, dsg_cur_thr;
  logic signed [15:0] taper_cur, inh_lo, inh_hi, sus_lo, sus_hi, hys;
  logic        [15:0] otc_time, otd_time, taper_v, chg_v, taper_win, terminate_alarm_threshold, full_charge_threshold;
  assign otc_thr     = thr_q[W_OTC_LVL][15:0];
  assign otc_rec     = thr_q[W_OTC_LVL][31:16];
  assign chg_cur_thr = thr_q[W_OTC_TIME][15:0];
  assign otc_time    = thr_q[W_OTC_TIME][31:16];
  assign otd_thr     = thr_q[W_OTD_LVL][15:0];
  assign otd_rec     = thr_q[W_OTD_LVL][31:16];
  assign dsg_cur_thr = thr_q[W_OTD_TIME][15:0];
  assign otd_time    = thr_q[W_OTD_TIME][31:16];
  assign taper_cur   = thr_q[W_TAPER][15:0];
  assign taper_v     = thr_q[W_TAPER][31:16];
  assign chg_v       = thr_q[W_CHGV][15:0];
  assign taper_win   = thr_q[W_CHGV][31:16];
  assign inh_lo      = thr_q[W_INHIBIT][15:0];
  assign inh_hi      = thr_q[W_INHIBIT][31:16];
  assign sus_lo      = thr_q[W_SUSPEND][15:0];
  assign sus_hi      = thr_q[W_SUSPEND][31:16];
  assign terminate_alarm_threshold     = thr_q[W_ALARMS][15:0];
  assign full_charge_threshold      = thr_q[W_ALARMS][31:16];
  assign hys         = thr_q[W_HYST][15:0];

  // configuration outputs
  assign reserve_rate_comp_en    = cfg_q[BIT_RESCOMP];
  assign adc_ground_select       = cfg_q[BIT_ADC_GROUND_SELECT];
  assign wake_range_select       = cfg_q[BIT_WAKERNG];
  assign sense_res_sel_hi        = cfg_q[BIT_RSEL_HI];
  assign sense_res_sel_lo        = cfg_q[BIT_RSEL_LO];
  assign res_factor_step_en      = cfg_q[BIT_RESSTEP];
  assign sleep_allowed           = cfg_q[BIT_SLEEPOK];
  assign shutdown_feature_en     = cfg_q[BIT_SDEN];
  assign external_thermistor_sel = cfg_q[BIT_EXTTHERM];

  // shutdown pin: open drain only pulls low, so the high level needs push-pull
  logic sd_level;
  assign sd_level        = (shutdown_feature_en && ready_for_shutdown) ?
                           cfg_q[BIT_SDPOL] : !cfg_q[BIT_SDPOL];
  assign shutdown_pin_o  = sd_level;
  assign shutdown_pin_oe = cfg_q[BIT_SDPP] || !sd_level;

  // measurement comparisons
  logic signed [16:0] t17;
  logic               charging, discharging, in_narrow;
  assign t17         = 17'(meas.temperature);
  assign charging    = meas.avg_current > chg_cur_thr;
  assign discharging = 17'(meas.avg_current) <= -17'(dsg_cur_thr);
  assign in_narrow   = (t17 >= 17'(inh_lo) + 17'(hys)) && (t17 <= 17'(inh_hi) - 17'(hys));

  // over-temperature timers count measurement updates
  logic [15:0] otc_cnt_q, otd_cnt_q;
  logic        otc_cond, otd_cond;
  assign otc_cond = charging && (meas.temperature >= otc_thr);
  assign otd_cond = discharging && (meas.temperature >= otd_thr);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      otc_cnt_q            <= 16'h0000;
      overtemp_charge_flag <= 1'b0;
    end else if (meas_update) begin
      otc_cnt_q <= (otc_cond && otc_cnt_q != 16'hFFFF) ? otc_cnt_q + 16'h0001 :
                   (otc_cond ? otc_cnt_q : 16'h0000);
      if (otc_time != 16'h0000 && otc_cond && otc_cnt_q + 16'h0001 >= otc_time) begin
        overtemp_charge_flag <= 1'b1;
      end else if (meas.temperature <= otc_rec) begin
        overtemp_charge_flag <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      otd_cnt_q               <= 16'h0000;
      overtemp_discharge_flag <= 1'b0;
    end else if (meas_update) begin
      otd_cnt_q <= (otd_cond && otd_cnt_q != 16'hFFFF) ? otd_cnt_q + 16'h0001 :
                   (otd_cond ? otd_cnt_q : 16'h0000);
      if (otd_time != 16'h0000 && otd_cond && otd_cnt_q + 16'h0001 >= otd_time) begin
        overtemp_discharge_flag <= 1'b1;
      end else if (meas.temperature <= otd_rec) begin
        overtemp_discharge_flag <= 1'b0;
      end
    end
  end

  // inhibit and suspend share the narrowed inhibit range for release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      charge_inhibit_flag <= 1'b0;
      charge_suspend_flag <= 1'b0;
    end else if (meas_update) begin
      if (meas.temperature < inh_lo || meas.temperature > inh_hi) begin
        charge_inhibit_flag <= 1'b1;
      end else if (in_narrow) begin
        charge_inhibit_flag <= 1'b0;
      end
      if (meas.temperature < sus_lo || meas.temperature > sus_hi) begin
        charge_suspend_flag <= 1'b1;
      end else if (in_narrow) begin
        charge_suspend_flag <= 1'b0;
      end
    end
  end

  // taper detection, one window is taper_win updates (zero treated as one)
  logic [15:0] win_cnt_q;
  logic [23:0] win_cap_q;
  logic        win_ok_q;
  logic [1:0]  good_q;
  logic        win_end, upd_ok, cap_ok, win_good, taper_event;
  logic [23:0] cap_next;
  assign upd_ok   = (meas.avg_current < taper_cur) &&
                    (17'(meas.voltage) > 17'(chg_v) - 17'(taper_v));
  assign cap_next = win_cap_q + 24'(meas.cap_delta);
  assign cap_ok   = $signed(cap_next) > $signed(TAPER_MIN_CMAH);
  assign win_end  = meas_update && (win_cnt_q + 16'h0001 >= taper_win);
  assign win_good = win_ok_q && upd_ok && cap_ok;
  assign taper_event = win_end && win_good && (good_q >= TAPER_WINDOWS - 2'd1) &&
                       charge_active_flag;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      win_cnt_q <= 16'h0000;
      win_cap_q <= 24'h000000;
      win_ok_q  <= 1'b1;
      good_q    <= 2'd0;
    end else if (win_end) begin
      win_cnt_q <= 16'h0000;
      win_cap_q <= 24'h000000;
      win_ok_q  <= 1'b1;
      // consecutive good windows; a bad one restarts the count
      // saturates so a long good run before charging cannot wrap the count
      good_q    <= (!win_good || taper_event) ? 2'd0 :
                   (good_q >= TAPER_WINDOWS - 2'd1) ? good_q : good_q + 2'd1;
    end else if (meas_update) begin
      win_cnt_q <= win_cnt_q + 16'h0001;
      win_cap_q <= cap_next;
      win_ok_q  <= win_ok_q && upd_ok;
    end
  end

  // charge state indications; events win over clears
  logic tca_hit, fc_hit;
  assign tca_hit = (terminate_alarm_threshold != ALARM_OFF) && (meas.soc >= terminate_alarm_threshold);
  assign fc_hit  = (full_charge_threshold != ALARM_OFF) && (meas.soc >= full_charge_threshold);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      charge_active_flag    <= 1'b0;
      terminate_charge_flag <= 1'b0;
      full_charge_flag      <= 1'b0;
      charge_term_pulse     <= 1'b0;
    end else begin
      charge_term_pulse <= taper_event;
      if (meas_update) begin
        if (taper_event) begin
          charge_active_flag <= 1'b0;
        end else if (charging && !full_charge_flag) begin
          charge_active_flag <= 1'b1;
        end
        if (taper_event || (charging && tca_hit)) begin
          terminate_charge_flag <= 1'b1;
        end else if (discharging) begin
          terminate_charge_flag <= 1'b0;
        end
        if (taper_event || (charging && fc_hit)) begin
          full_charge_flag <= 1'b1;
        end else if (discharging) begin
          full_charge_flag <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      remaining_capacity_value <= 16'h0000;
    end else if (meas_update) begin
      remaining_capacity_value <= (taper_event && cfg_q[BIT_RMFULL]) ?
                                  meas.full_capacity : meas.remaining_in;
    end
  end

  // read data
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (paddr == ADDR_CONFIG) begin
      rd_mux = {16'h0000, cfg_q};
    end else if (paddr == ADDR_FLAGS) begin
      rd_mux[FLG_OTC]  = overtemp_charge_flag;
      rd_mux[FLG_OTD]  = overtemp_discharge_flag;
      rd_mux[FLG_INH]  = charge_inhibit_flag;
      rd_mux[FLG_SUSP] = charge_suspend_flag;
      rd_mux[FLG_CHG]  = charge_active_flag;
      rd_mux[FLG_TERM] = terminate_charge_flag;
      rd_mux[FLG_FULL] = full_charge_flag;
    end else if (paddr == ADDR_CFG_LOC) begin
      rd_mux = {16'h0000, CFG_SUBCLASS, CFG_SUBCLASS_OFFSET};
    end else if (in_thr) begin
      rd_mux = (thr_idx == 4'(W_HYST)) ? {16'h0000, hys} : thr_q[thr_idx];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rd_mux;
    end
  end

  // checks
  a_cfg_reset_dflt: assert property (@(posedge pclk)
    $rose(presetn) |-> cfg_q == CFG_RESET)
    else $error("config word not at default after reset");

  a_sleep_follows: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == ADDR_CONFIG && pstrb[0]) |=> sleep_allowed == $past(pwdata[BIT_SLEEPOK]))
    else $error("sleep permission did not follow write");

  a_otc_disabled: assert property (@(posedge pclk) disable iff (!presetn)
    (otc_time == 16'h0000 && !overtemp_charge_flag) |=> !overtemp_charge_flag)
    else $error("charge overtemp set while disabled");

  a_otc_recover: assert property (@(posedge pclk) disable iff (!presetn)
    (meas_update && meas.temperature <= otc_rec && !otc_cond) |=> !overtemp_charge_flag)
    else $error("charge overtemp not released at recovery");

  a_otd_set: assert property (@(posedge pclk) disable iff (!presetn)
    (meas_update && otd_time != 16'h0000 && otd_cond && otd_cnt_q + 16'h0001 >= otd_time)
    |=> overtemp_discharge_flag)
    else $error("discharge overtemp not set");

  a_otd_recover: assert property (@(posedge pclk) disable iff (!presetn)
    (meas_update && meas.temperature <= otd_rec && !otd_cond) |=> !overtemp_discharge_flag)
    else $error("discharge overtemp not released");

  a_term_clears_chg: assert property (@(posedge pclk) disable iff (!presetn)
    (meas_update && taper_event) |=> !charge_active_flag && charge_term_pulse)
    else $error("termination did not clear charge flag");

  a_rm_load_full: assert property (@(posedge pclk) disable iff (!presetn)
    (meas_update && taper_event && cfg_q[BIT_RMFULL])
    |=> remaining_capacity_value == $past(meas.full_capacity))
    else $error("remaining capacity not loaded from full");

  a_fc_off_taper: assert property (@(posedge pclk) disable iff (!presetn)
    (full_charge_threshold == ALARM_OFF && !full_charge_flag && !taper_event) |=> !full_charge_flag)
    else $error("full charge set without taper");

  a_inhibit_set: assert property (@(posedge pclk) disable iff (!presetn)
    (meas_update && (meas.temperature < inh_lo || meas.temperature > inh_hi))
    |=> charge_inhibit_flag)
    else $error("inhibit not set outside limits");

  a_suspend_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (charge_suspend_flag && !(meas_update && in_narrow)) |=> charge_suspend_flag)
    else $error("suspend released outside narrowed range");

  a_sd_level: assert property (@(posedge pclk) disable iff (!presetn)
    (shutdown_feature_en && ready_for_shutdown) |-> shutdown_pin_o == cfg_q[BIT_SDPOL])
    else $error("shutdown pin level wrong");

endmodule
`default_nettype wire

// [testbench/pcf_meas_src.sv]
// Purpose: measurement source feeding the flag block, one set per request
// Assumes: request is a level held by the bench for one cycle
// Notes:   between updates the set is scrambled so stale data is never trusted
`timescale 1ns/1ns
`default_nettype none
module pcf_meas_src
  import pcf_pkg::*;
(
  // clock and request
  input  wire logic      pclk,
  input  wire logic      presetn,
  input  wire logic      req,
  input  wire pcf_meas_t req_meas,
  // toward the gauge
  output logic           meas_update,
  output pcf_meas_t      meas
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meas_update <= 1'b0;
      meas        <= '0;
    end else begin
      meas_update <= req;
      meas        <= req ? req_meas : ~meas;
    end
  end
endmodule
`default_nettype wire

// [testbench/pcf_flags_tb_top.sv]
// Purpose: self-checking bench for the configuration word and flag logic
// Assumes: zero-wait apb slave, flags readable at the flag word
// Notes:   read results are queued by the driver and checked by a monitor
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin mismatches++; \
  $display("CHECK FAILED t=%0t act=%h exp=%h", $time, a, e); end end
module pcf_flags_tb_top
  import pcf_pkg::*;
;
  logic              pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [PCF_AW-1:0] paddr = '0;
  logic [31:0]       pwdata = '0, prdata, w;
  logic [3:0]        pstrb = 4'hF;
  logic              pready, pslverr, meas_update, ready_for_shutdown = 0, req = 0, o;
  pcf_meas_t         meas, rq = '0;
  logic reserve_rate_comp_en, adc_ground_select, wake_range_select, sense_res_sel_hi;
  logic sense_res_sel_lo, res_factor_step_en, sleep_allowed, external_thermistor_sel;
  logic shutdown_feature_en, shutdown_pin_o, shutdown_pin_oe, overtemp_charge_flag;
  logic overtemp_discharge_flag, charge_inhibit_flag, charge_suspend_flag;
  logic charge_active_flag, terminate_charge_flag, full_charge_flag, charge_term_pulse;
  logic [15:0] remaining_capacity_value;
  logic [32:0] e_v, exp_q[$];
  logic [23:0] e_u, upd_q[$];
  logic [8:0]  cfg_o;
  logic [6:0]  flg_o;
  logic        upd_d = 0;
  int mismatches = 0, checked = 0;

  always #20 pclk = ~pclk;

  pcf_meas_src i_pcf_meas_src (.pclk, .presetn, .req, .req_meas(rq), .meas_update, .meas);
  pcf_flags i_pcf_flags (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .prdata, .pready, .pslverr, .meas_update, .meas, .ready_for_shutdown,
    .reserve_rate_comp_en, .adc_ground_select, .wake_range_select, .sense_res_sel_hi,
    .sense_res_sel_lo, .res_factor_step_en, .sleep_allowed, .external_thermistor_sel,
    .shutdown_feature_en, .shutdown_pin_o, .shutdown_pin_oe, .overtemp_charge_flag,
    .overtemp_discharge_flag, .charge_inhibit_flag, .charge_suspend_flag,
    .charge_active_flag, .terminate_charge_flag, .full_charge_flag, .charge_term_pulse,
    .remaining_capacity_value);

  function automatic logic [7:0] thr(input int i);
    return ADDR_THR_BASE + 8'(4 * i);
  endfunction

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] e, input logic err = 1'b0);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    penable <= 1'b0;
    if (!wr) exp_q.push_back({err, e});
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, e);
  endtask

  // one measurement update; flag ports, pulse and capacity noted, flag word read back
  task automatic upd(input logic signed [15:0] t, input logic signed [15:0] c,
                     input logic [6:0] f, input logic p = 1'b0);
    @(posedge pclk);
    req             <= 1'b1;
    rq.temperature  <= t;
    rq.avg_current  <= c;
    rq.remaining_in <= 16'($urandom);
    @(posedge pclk);
    req <= 1'b0;
    upd_q.push_back({p, f, p ? rq.full_capacity : rq.remaining_in});
    rd(ADDR_FLAGS, {25'h0, f});
  endtask

  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) begin
      e_v = exp_q.pop_front();
      `CHK({pslverr, prdata}, e_v)
    end
  end

  assign cfg_o = {reserve_rate_comp_en, adc_ground_select, wake_range_select, sense_res_sel_hi,
                  sense_res_sel_lo, res_factor_step_en, sleep_allowed, shutdown_feature_en,
                  external_thermistor_sel};
  assign flg_o = {full_charge_flag, terminate_charge_flag, charge_active_flag,
                  charge_suspend_flag, charge_inhibit_flag, overtemp_discharge_flag,
                  overtemp_charge_flag};

  // results of an update stand in the cycle after the design took it
  always @(posedge pclk) begin
    upd_d <= meas_update;
    if (upd_d) begin
      e_u = upd_q.pop_front();
      `CHK({charge_term_pulse, flg_o, remaining_capacity_value}, e_u)
    end
  end

  task automatic summarize();
    $display("checked=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge pclk);
    mismatches++;
    summarize();
  end

  initial begin
    void'($urandom(88167));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rd(ADDR_CONFIG, 32'h0000_0177);
    rd(ADDR_CFG_LOC, 32'h0000_4000);
    rd(thr(W_ALARMS), 32'hFFFF_FFFF);
    apb(1'b0, 8'h3C, 32'h0, 32'h0, 1'b1);
    $display("reset values done");
    repeat (6) begin
      w = $urandom;
      apb(1'b1, ADDR_CONFIG, w, 32'h0);
      rd(ADDR_CONFIG, w & 32'h0000_8F7F);
      ready_for_shutdown <= 1'($urandom);
      @(posedge pclk);
      o = (w[1] & ready_for_shutdown) ? w[2] : ~w[2];
      `CHK({shutdown_pin_o, shutdown_pin_oe}, {o, w[3] | ~o})
      `CHK(cfg_o, {w[15], w[11:8], w[6:5], w[1:0]})
    end
    $display("config word done");
    // inhibit window kept inside the suspend window
    apb(1'b1, thr(W_INHIBIT), {16'd400, 16'd200}, 32'h0);
    apb(1'b1, thr(W_SUSPEND), {16'd450, 16'd150}, 32'h0);
    apb(1'b1, thr(W_HYST), 32'd10, 32'h0);
    upd(401, 0, 7'h04);
    upd(395, 0, 7'h04);
    upd(390, 0, 7'h00);
    upd(149, 0, 7'h0C);
    upd(205, 0, 7'h0C);
    upd(210, 0, 7'h00);
    $display("inhibit and suspend done");
    apb(1'b1, thr(W_OTC_LVL), {16'd300, 16'd350}, 32'h0);
    apb(1'b1, thr(W_OTC_TIME), {16'd2, 16'd10}, 32'h0);
    upd(350, 20, 7'h10);
    upd(350, 20, 7'h11);
    upd(320, 20, 7'h11);
    upd(300, 20, 7'h10);
    $display("over-temperature done");
    // taper needs current, voltage and capacity good in two windows of one update
    apb(1'b1, ADDR_CONFIG, {16'h0, CFG_RESET}, 32'h0);
    apb(1'b1, thr(W_TAPER), {16'd100, 16'd50}, 32'h0);
    apb(1'b1, thr(W_CHGV), {16'd1, 16'd4200}, 32'h0);
    apb(1'b1, thr(W_OTD_LVL), {16'd280, 16'd300}, 32'h0);
    apb(1'b1, thr(W_OTD_TIME), {16'd1, 16'd10}, 32'h0);
    rq.voltage       <= 16'd4150;
    rq.cap_delta     <= 16'sd30;
    rq.full_capacity <= 16'($urandom);
    upd(300, 20, 7'h10);
    upd(300, 20, 7'h60, 1'b1);
    upd(300, 20, 7'h60);
    upd(300, -20, 7'h02);
    upd(280, -20, 7'h00);
    $display("taper and discharge done");
    repeat (3) @(posedge pclk);
    summarize();
  end
endmodule
`default_nettype wire
